//--- verilog/adc_cfg_pkg.sv
// Purpose: shared constants for the converter's digital processing configuration
// Assumes: 16-bit serial frames, address byte first, msb first
// Notes: Function list below
// Function
// - Coefficient select picks built-in or user set
// - Offset correction runs only when enabled
// - Band field in bits 1:0 of 0x1d
// - Divide-by-two band codes 00/01 select low/high pass, 10/11 bypass
// - Divide-by-four band codes select four responses
// - Reset pin low makes pins serial port
// - Parallel mode: enable pin sets interface/format
// - Three control pins decode power-down and mux
// - Decimation ratio codes decode, custom-only modes
package adc_cfg_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_SW_RESET = 8'h00;
  localparam logic [7:0] ADDR_PROC_CTRL = 8'h1b;
  localparam logic [7:0] ADDR_BAND = 8'h1d;
  localparam logic [7:0] ADDR_COEF_BASE = 8'h40;
  // ==========================================================
  // field positions
  localparam int SW_RESET_BIT = 1;
  localparam int OFFS_EN_BIT = 7;
  localparam int COEF_SEL_BIT = 5;
  localparam int DECIM_EN_BIT = 4;
  localparam int ODD_TAP_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int BAND_LSB = 0;
  // ==========================================================
  // reset values
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic [1:0] BAND_RST = 2'h0;
  // ==========================================================
  // decimation ratio and band codes
  localparam logic [2:0] RATE_DIV2 = 3'h0;
  localparam logic [2:0] RATE_DIV4 = 3'h1;
  localparam logic [2:0] RATE_NODEC = 3'h3;
  localparam logic [2:0] RATE_DIV8 = 3'h4;
  localparam logic [1:0] BAND_00 = 2'h0;
  localparam logic [1:0] BAND_01 = 2'h1;
  localparam logic [1:0] BAND_10 = 2'h2;
  localparam logic [1:0] BAND_11 = 2'h3;
  // ==========================================================
  // filter response codes
  localparam logic [2:0] RESP_BYPASS = 3'h0;
  localparam logic [2:0] RESP_LP_FS4 = 3'h1;
  localparam logic [2:0] RESP_HP_FS4 = 3'h2;
  localparam logic [2:0] RESP_LP_FS8 = 3'h3;
  localparam logic [2:0] RESP_BP_3FS16 = 3'h4;
  localparam logic [2:0] RESP_BP_5FS16 = 3'h5;
  localparam logic [2:0] RESP_HP_3FS8 = 3'h6;
  localparam logic [2:0] RESP_CUSTOM = 3'h7;
  // ==========================================================
  // framing, pins and timing
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int COEF_TAPS = 24;
  localparam int EST_SHIFT = 8;
  localparam int NPINS = 7;
  localparam int PIN_RST = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DATA = 2;
  localparam int PIN_ENABLE = 3;
  localparam int PIN_CTRL_LO = 4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } port_state_type;
endpackage : adc_cfg_pkg

//--- verilog/coef_mem.sv
// Purpose: user coefficient storage with registered read
// Assumes: single write port, single read port, same clock
// Notes: contents are not cleared by reset, only overwritten
module coef_mem #(
  parameter int DEPTH = 24,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata_r
);
  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // storage; read data lags the address by one edge
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule : coef_mem

//--- verilog/adc_decim_filter_config.sv
// Purpose: dual-purpose control pins, serial config port, filter setup, offset correction
// Assumes: pins are asynchronous to clk; reset_pin high means parallel control
// Notes: serial bits sampled on the rising edge of the filtered clock pin
module adc_decim_filter_config
  import adc_cfg_pkg::*;
#(
  parameter int SAMPLE_W = 11,
  parameter int COEF_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_config_data_pin,
  input wire logic serial_transfer_enable_pin,
  input wire logic control_input_one,
  input wire logic control_input_two,
  input wire logic control_input_three,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid,
  input wire logic [4:0] coef_rd_addr,
  output logic [COEF_W-1:0] coef_rd_data,
  output logic coef_use_user,
  output logic [2:0] decim_ratio,
  output logic decim_enable,
  output logic odd_tap_enable,
  output logic [2:0] filter_response,
  output logic offset_corr_active,
  output logic [SAMPLE_W-1:0] sample_out,
  output logic sample_out_valid,
  output logic parallel_mode,
  output logic gain_ref_ctrl,
  output logic iface_fmt_ctrl,
  output logic [2:0] ctrl_mode_code
);
  localparam int EST_W = SAMPLE_W + EST_SHIFT;

  typedef struct packed {
    logic [NPINS-1:0][2:0] sync;
    logic [NPINS-1:0] pin_r;
    logic [NPINS-1:0] pin_prev;
    port_state_type state;
    logic [15:0] shift_r;
    logic [4:0] bit_cnt;
    logic offs_en;
    logic coef_user;
    logic decim_en;
    logic odd_tap;
    logic [2:0] rate;
    logic [1:0] band;
    logic user_eff;
    logic [2:0] response;
    logic [EST_W-1:0] est;
    logic [SAMPLE_W-1:0] smp_out;
    logic smp_vld;
    logic gain_ref;
    logic iface_fmt;
    logic [2:0] ctrl_code;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic [NPINS-1:0] pins;
  logic coef_we;
  logic [4:0] coef_waddr;
  logic [COEF_W-1:0] coef_wdata;
  logic par;
  logic sclk_rise;
  logic enable_rise;
  logic commit;
  logic signed [EST_W-1:0] diff;
  logic [7:0] waddr_full;

  assign pins = {control_input_three, control_input_two, control_input_one,
                 serial_transfer_enable_pin, serial_config_data_pin,
                 serial_clock_pin, reset_pin};

  // ==========================================================
  // next-state logic
  always_comb begin
    s_nxt = s_r;
    coef_we = 1'b0;
    coef_waddr = 5'h00;
    coef_wdata = '0;
    diff = '0;
    waddr_full = 8'h00;
    // three-stage pin filter; a level counts once stages two and three agree
    for (int p = 0; p < NPINS; p++) begin
      s_nxt.sync[p] = {s_r.sync[p][1:0], pins[p]};
      if (s_r.sync[p][1] == s_r.sync[p][2]) begin
        s_nxt.pin_r[p] = s_r.sync[p][2];
      end
    end
    s_nxt.pin_prev = s_r.pin_r;
    par = s_r.pin_r[PIN_RST];
    sclk_rise = s_r.pin_r[PIN_SCLK] & ~s_r.pin_prev[PIN_SCLK];
    enable_rise = s_r.pin_r[PIN_ENABLE] & ~s_r.pin_prev[PIN_ENABLE];
    commit = 1'b0;

    case (s_r.state)
      ST_IDLE: begin
        s_nxt.bit_cnt = 5'h00;
        if (!par && !s_r.pin_r[PIN_ENABLE]) begin
          s_nxt.state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (par) begin
          s_nxt.state = ST_IDLE;
        end else if (enable_rise) begin
          commit = (s_r.bit_cnt == FRAME_BITS);
          s_nxt.state = ST_IDLE;
        end else if (sclk_rise && !s_r.pin_r[PIN_ENABLE]) begin
          s_nxt.shift_r = {s_r.shift_r[14:0], s_r.pin_r[PIN_DATA]};
          // extra bits keep the last sixteen but spoil the count, so the frame is dropped
          if (s_r.bit_cnt != FRAME_BITS + 5'h01) begin
            s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
          end
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase

    // register writes
    if (commit) begin
      waddr_full = s_r.shift_r[15:8];
      if (waddr_full == ADDR_PROC_CTRL) begin
        s_nxt.offs_en = s_r.shift_r[OFFS_EN_BIT];
        s_nxt.coef_user = s_r.shift_r[COEF_SEL_BIT];
        s_nxt.decim_en = s_r.shift_r[DECIM_EN_BIT];
        s_nxt.odd_tap = s_r.shift_r[ODD_TAP_BIT];
        s_nxt.rate = s_r.shift_r[RATE_LSB +: 3];
      end
      if (waddr_full == ADDR_BAND) begin
        s_nxt.band = s_r.shift_r[BAND_LSB +: 2];
      end
      if (waddr_full >= ADDR_COEF_BASE && waddr_full < ADDR_COEF_BASE + 8'(COEF_TAPS)) begin
        coef_we = 1'b1;
        coef_waddr = 5'(waddr_full - ADDR_COEF_BASE);
        coef_wdata = s_r.shift_r[7:0];
      end
    end

    // pin pulse or software reset restores defaults
    // parallel mode holds processing at defaults
    if (par || (commit && waddr_full == ADDR_SW_RESET && s_r.shift_r[SW_RESET_BIT])) begin
      s_nxt.offs_en = 1'b0;
      s_nxt.coef_user = 1'b0;
      s_nxt.decim_en = 1'b0;
      s_nxt.odd_tap = 1'b0;
      s_nxt.rate = RATE_RST;
      s_nxt.band = BAND_RST;
    end

    s_nxt.user_eff = s_r.coef_user || (s_r.decim_en &&
                     (s_r.rate == RATE_NODEC || s_r.rate == RATE_DIV8));

    s_nxt.response = RESP_BYPASS;
    if (s_r.decim_en) begin
      case (s_r.rate)
        RATE_DIV2: begin
          if (s_r.band == BAND_00) s_nxt.response = RESP_LP_FS4;
          else if (s_r.band == BAND_01) s_nxt.response = RESP_HP_FS4;
        end
        RATE_DIV4: begin
          case (s_r.band)
            BAND_00: s_nxt.response = RESP_LP_FS8;
            BAND_01: s_nxt.response = RESP_BP_3FS16;
            BAND_10: s_nxt.response = RESP_BP_5FS16;
            default: s_nxt.response = RESP_HP_3FS8;
          endcase
        end
        RATE_NODEC, RATE_DIV8: s_nxt.response = RESP_CUSTOM;
        default: s_nxt.response = RESP_BYPASS;
      endcase
    end

    // offset correction: slow running mean subtracted from the stream
    if (!s_r.offs_en) begin
      s_nxt.est = '0;
      if (sample_valid) s_nxt.smp_out = sample_in;
    end else if (sample_valid) begin
      diff = $signed({sample_in, {EST_SHIFT{1'b0}}}) - $signed(s_r.est);
      s_nxt.est = EST_W'($signed(s_r.est) + (diff >>> EST_SHIFT));
      s_nxt.smp_out = SAMPLE_W'(sample_in - s_r.est[EST_W-1 -: SAMPLE_W]);
    end
    s_nxt.smp_vld = sample_valid;

    // parallel levels; gain and format are zero in serial mode, control code follows its pins in both modes
    s_nxt.gain_ref = par & s_r.pin_r[PIN_SCLK];
    s_nxt.iface_fmt = par & s_r.pin_r[PIN_ENABLE];
    s_nxt.ctrl_code = s_r.pin_r[PIN_CTRL_LO +: 3];
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      // enable pin idles high on its pull-up; starting at zero would fake a frame end
      s_r.sync[PIN_ENABLE] <= 3'h7;
      s_r.pin_r[PIN_ENABLE] <= 1'b1;
      s_r.pin_prev[PIN_ENABLE] <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  coef_mem #(.DEPTH(COEF_TAPS), .WIDTH(COEF_W)) u_coef_mem (
    .clk(clk),
    .we(coef_we),
    .waddr(coef_waddr),
    .wdata(coef_wdata),
    .raddr(coef_rd_addr),
    .rdata_r(coef_rd_data)
  );

  // ==========================================================
  // outputs
  assign coef_use_user = s_r.user_eff;
  assign decim_ratio = s_r.rate;
  assign decim_enable = s_r.decim_en;
  assign odd_tap_enable = s_r.odd_tap;
  assign filter_response = s_r.response;
  assign offset_corr_active = s_r.offs_en;
  assign sample_out = s_r.smp_out;
  assign sample_out_valid = s_r.smp_vld;
  assign parallel_mode = s_r.pin_r[PIN_RST];
  assign gain_ref_ctrl = s_r.gain_ref;
  assign iface_fmt_ctrl = s_r.iface_fmt;
  assign ctrl_mode_code = s_r.ctrl_code;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence band_frame_s;
    (s_r.state == ST_SHIFT) && enable_rise && !par && s_r.bit_cnt == FRAME_BITS
      && s_r.shift_r[15:8] == ADDR_BAND;
  endsequence

  a_coef_builtin: assert property ((!s_r.coef_user && s_r.rate == RATE_DIV4) |=>
    !coef_use_user) else $error("built-in coefficients not selected");
  a_offset_bypass: assert property ((!s_r.offs_en && sample_valid) |=>
    (sample_out == $past(sample_in) && s_r.est == '0)) else $error("offset not bypassed");
  a_band_commit: assert property (band_frame_s |=>
    s_r.band == $past(s_r.shift_r[1:0])) else $error("band write not applied");
  a_div2_lowpass: assert property ((s_r.decim_en && s_r.rate == RATE_DIV2 &&
    s_r.band == BAND_00) |=> filter_response == RESP_LP_FS4) else $error("div2 band 00 wrong");
  a_div4_bandpass: assert property ((s_r.decim_en && s_r.rate == RATE_DIV4 &&
    s_r.band == BAND_10) |=> filter_response == RESP_BP_5FS16) else $error("div4 band 10 wrong");
  a_par_defaults: assert property (par |=>
    (!s_r.decim_en && !s_r.offs_en && s_r.band == BAND_RST)) else $error("defaults not held");
  a_serial_par_idle: assert property (par |=> s_r.state == ST_IDLE)
    else $error("serial port active in parallel mode");
  a_gain_level: assert property (par |=> gain_ref_ctrl == $past(s_r.pin_r[PIN_SCLK]))
    else $error("gain/reference level wrong");
  a_iface_level: assert property (par |=> iface_fmt_ctrl == $past(s_r.pin_r[PIN_ENABLE]))
    else $error("interface level wrong");
  a_ctrl_code: assert property (1'b1 |=>
    ctrl_mode_code == $past(s_r.pin_r[PIN_CTRL_LO +: 3])) else $error("control code wrong");
  a_custom_only: assert property ((s_r.decim_en && s_r.rate == RATE_DIV8) |=>
    (coef_use_user && filter_response == RESP_CUSTOM)) else $error("div8 not custom");
  a_no_early_write: assert property ((s_r.state == ST_SHIFT && !enable_rise && !par) |=>
    $stable(s_r.band)) else $error("band changed mid-frame");
endmodule : adc_decim_filter_config

//--- tb/serial_ctrl_model.sv
// Purpose: controller driving the dual-purpose configuration pins
// Assumes: pins change only at falling clk edges
// Notes: hold_cyc sets each pin hold; raise it to model a slow controller
module serial_ctrl_model (
  input wire logic clk,
  output logic reset_pin,
  output logic serial_clock_pin,
  output logic serial_config_data_pin,
  output logic serial_transfer_enable_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold_cyc = 5;
  // pins idle at their pull levels
  initial begin
    reset_pin = 1'b0;
    serial_clock_pin = 1'b0;
    serial_config_data_pin = 1'b0;
    serial_transfer_enable_pin = 1'b1;
  end
  // pin filter needs four cycles, so every level is held at least that long
  task automatic hold();
    repeat (hold_cyc) @(negedge clk);
  endtask : hold
  task automatic init_serial();
    reset_pin = 1'b1;
    hold();
    reset_pin = 1'b0;
    serial_clock_pin = 1'b0;
    serial_transfer_enable_pin = 1'b1;
    hold();
  endtask : init_serial
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [15:0] word;
    word = {addr, data};
    serial_transfer_enable_pin = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_config_data_pin = word[i];
      hold();
      serial_clock_pin = 1'b1;
      hold();
      serial_clock_pin = 1'b0;
    end
    hold();
    serial_transfer_enable_pin = 1'b1;
    // released data line falls to its pull-down
    serial_config_data_pin = 1'b0;
    hold();
  endtask : write_reg
  task automatic set_parallel(input logic gain_ref, input logic fmt);
    reset_pin = 1'b1;
    serial_clock_pin = gain_ref;
    serial_transfer_enable_pin = fmt;
  endtask : set_parallel
endmodule : serial_ctrl_model

//--- tb/adc_decim_filter_config_tb.sv
// Purpose: self-checking bench for the filter configuration block
// Assumes: serial frames come from serial_ctrl_model
// Notes: waits after writes cover the pin filter latency
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module adc_decim_filter_config_tb;
  import adc_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin, sclk, data_pin, enable_pin;
  logic c1 = 1'b0, c2 = 1'b0, c3 = 1'b0;
  logic [10:0] sample_in = 11'h000;
  logic sample_valid = 1'b0;
  logic [4:0] coef_rd_addr = 5'h00;
  logic [7:0] coef_rd_data;
  logic coef_use_user, decim_enable, odd_tap_enable, offset_corr_active;
  logic [2:0] decim_ratio, filter_response, ctrl_mode_code;
  logic [10:0] sample_out;
  logic sample_out_valid, parallel_mode, gain_ref_ctrl, iface_fmt_ctrl;
  int err_count = 0;
  int check_count = 0;
  logic [2:0] exp_resp [8] = '{RESP_LP_FS4, RESP_HP_FS4, RESP_BYPASS, RESP_BYPASS,
    RESP_LP_FS8, RESP_BP_3FS16, RESP_BP_5FS16, RESP_HP_3FS8};
  always #2.5 clk = ~clk;
  serial_ctrl_model i_ctl (.clk(clk), .reset_pin(reset_pin), .serial_clock_pin(sclk),
    .serial_config_data_pin(data_pin), .serial_transfer_enable_pin(enable_pin));
  adc_decim_filter_config i_dut (.clk(clk), .rst_n(rst_n), .reset_pin(reset_pin),
    .serial_clock_pin(sclk), .serial_config_data_pin(data_pin),
    .serial_transfer_enable_pin(enable_pin), .control_input_one(c1), .control_input_two(c2),
    .control_input_three(c3), .sample_in(sample_in), .sample_valid(sample_valid),
    .coef_rd_addr(coef_rd_addr), .coef_rd_data(coef_rd_data),
    .coef_use_user(coef_use_user), .decim_ratio(decim_ratio),
    .decim_enable(decim_enable), .odd_tap_enable(odd_tap_enable),
    .filter_response(filter_response), .offset_corr_active(offset_corr_active),
    .sample_out(sample_out), .sample_out_valid(sample_out_valid),
    .parallel_mode(parallel_mode), .gain_ref_ctrl(gain_ref_ctrl),
    .iface_fmt_ctrl(iface_fmt_ctrl), .ctrl_mode_code(ctrl_mode_code));
  // ==========================================================
  // helpers
  task automatic settle();
    repeat (10) @(negedge clk);
  endtask : settle
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    i_ctl.write_reg(addr, data);
    settle();
  endtask : wr
  task automatic summarize();
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // a hang counts as a mismatch; tests need about 5k cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    summarize();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    i_ctl.init_serial();
    `CHK(filter_response, RESP_BYPASS)
    `CHK(parallel_mode, 1'b0)
    // every band code under both ratios
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_PROC_CTRL, 8'h10 | 8'(k >> 2));
      wr(ADDR_BAND, 8'(k & 3));
      `CHK(filter_response, exp_resp[k])
      `CHK(decim_ratio, 3'(k >> 2))
    end
    // upper bits of the band register are dropped
    wr(ADDR_BAND, 8'hfe);
    `CHK(filter_response, RESP_BP_5FS16)
    wr(ADDR_PROC_CTRL, 8'h13);
    `CHK(filter_response, RESP_CUSTOM)
    `CHK(coef_use_user, 1'b1)
    wr(ADDR_PROC_CTRL, 8'h14);
    `CHK(decim_ratio, RATE_DIV8)
    `CHK(filter_response, RESP_CUSTOM)
    // coefficient source and odd taps
    wr(ADDR_PROC_CTRL, 8'h38);
    `CHK(coef_use_user, 1'b1)
    `CHK(odd_tap_enable, 1'b1)
    wr(ADDR_PROC_CTRL, 8'h10);
    `CHK(coef_use_user, 1'b0)
    `CHK(decim_enable, 1'b1)
    // slow controller loads both ends of the coefficient table
    i_ctl.hold_cyc = 9;
    wr(ADDR_COEF_BASE, 8'h5a);
    wr(ADDR_COEF_BASE + 8'h17, 8'ha5);
    i_ctl.hold_cyc = 5;
    coef_rd_addr = 5'h17;
    repeat (2) @(negedge clk);
    `CHK(coef_rd_data, 8'ha5)
    coef_rd_addr = 5'h00;
    repeat (2) @(negedge clk);
    `CHK(coef_rd_data, 8'h5a)
    // offset off passes samples unchanged
    wr(ADDR_PROC_CTRL, 8'h00);
    sample_in = 11'h523;
    sample_valid = 1'b1;
    @(negedge clk);
    `CHK(sample_out, 11'h523)
    `CHK(sample_out_valid, 1'b1)
    `CHK(offset_corr_active, 1'b0)
    sample_valid = 1'b0;
    wr(ADDR_PROC_CTRL, 8'h80);
    `CHK(offset_corr_active, 1'b1)
    // enabled correction starts from a zero mean, then subtracts the 1/256 step
    sample_in = 11'h100;
    sample_valid = 1'b1;
    @(negedge clk);
    `CHK(sample_out, 11'h100)
    @(negedge clk);
    `CHK(sample_out, 11'h0ff)
    sample_valid = 1'b0;
    // software reset clears settings
    wr(ADDR_PROC_CTRL, 8'h91);
    wr(ADDR_SW_RESET, 8'h02);
    `CHK(decim_ratio, RATE_RST)
    `CHK(offset_corr_active, 1'b0)
    // parallel control: pins become static levels
    i_ctl.set_parallel(1'b1, 1'b0);
    settle();
    `CHK(parallel_mode, 1'b1)
    `CHK(gain_ref_ctrl, 1'b1)
    `CHK(iface_fmt_ctrl, 1'b0)
    i_ctl.set_parallel(1'b0, 1'b1);
    settle();
    `CHK(gain_ref_ctrl, 1'b0)
    `CHK(iface_fmt_ctrl, 1'b1)
    for (int k = 0; k < 8; k++) begin
      {c3, c2, c1} = 3'(k);
      settle();
      `CHK(ctrl_mode_code, 3'(k))
    end
    summarize();
  end
endmodule : adc_decim_filter_config_tb
